// ==== core/dchr_defines.svh ====
// Register offsets, field positions, reset values and timing counts of the disk register bank
`ifndef DCHR_DEFINES_SVH
`define DCHR_DEFINES_SVH
// Host port addresses
`define DCHR_ADDR_DATA 10'h1f0
`define DCHR_ADDR_FOPS 10'h3f2
`define DCHR_ADDR_FMSR 10'h3f4
`define DCHR_ADDR_FSTK 10'h3f5
`define DCHR_ADDR_AUX 10'h3f6
`define DCHR_ADDR_DIAG 10'h3f7
// Auxiliary control fields
`define DCHR_AUX_RST_BIT 2
`define DCHR_AUX_IDS_BIT 1
`define DCHR_AUX_IDS_RST 1'h1
// Floppy operations fields
`define DCHR_FOPS_MBE_BIT 5
`define DCHR_FOPS_MAE_BIT 4
`define DCHR_FOPS_IDE_BIT 3
`define DCHR_FOPS_RST_BIT 2
`define DCHR_FOPS_DSB_BIT 0
`define DCHR_FOPS_RST_VAL 8'h00
// Floppy main status pass mask; bits 3 and 2 read as zero
`define DCHR_FMSR_ZERO_MASK 8'hf3
// Index of the last word of a sector
`define DCHR_LAST_WORD 8'hff
// Least auxiliary reset time and its cycle count at 50 MHz
`define DCHR_CLK_NS 20
`define DCHR_RST_MIN_NS 10000
`define DCHR_RST_MIN_CYC ((`DCHR_RST_MIN_NS + `DCHR_CLK_NS - 1) / `DCHR_CLK_NS)
`endif

// ==== core/dchr_pkg.sv ====
// Types shared by the disk register bank
package dchr_pkg;
	// Floppy data rates in register encoding order
	typedef enum logic [1:0] {
		DCHR_RATE_500K,
		DCHR_RATE_300K,
		DCHR_RATE_250K,
		DCHR_RATE_125K
	} dchr_rate_t;
	// Decoded host register target
	typedef enum logic [2:0] {
		DCHR_SEL_NONE,
		DCHR_SEL_DATA,
		DCHR_SEL_FOPS,
		DCHR_SEL_FMSR,
		DCHR_SEL_FSTK,
		DCHR_SEL_AUX,
		DCHR_SEL_DIAG
	} dchr_sel_t;
endpackage

// ==== core/dchr_sector_ram.sv ====
// Single-port sector buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
module dchr_sector_ram #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 256
) (
	// Clock
	input wire logic clock,
	// Access port
	input wire logic en,
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] addr,
	input wire logic [WIDTH-1:0] wdata,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	// Refuse shapes the pointer logic cannot serve
	initial
	begin
		if (WIDTH < 1 || DEPTH < 2)
			$error("dchr_sector_ram: bad shape");
	end

	// Write, or read into the output register
	always_ff @(posedge clock)
	begin
		if (en && we)
			mem[addr] <= wdata;
		if (en && !we)
			rdata <= mem[addr];
	end
endmodule
`default_nettype wire

// ==== core/dchr_host_regs.sv ====
// Host-visible register set of the fixed-disk and floppy controller
`timescale 1ns/1ps
`default_nettype none
`include "dchr_defines.svh"
module dchr_host_regs import dchr_pkg::*; #(
	parameter int WORDS = 256,
	parameter int RST_MIN_CYC = `DCHR_RST_MIN_CYC
) (
	// Clock and master reset
	input wire logic clock,
	input wire logic rst_n,
	// Host I/O bus pins
	input wire logic [9:0] sa,
	input wire logic aen,
	input wire logic ior_n,
	input wire logic iow_n,
	input wire logic [15:0] sd_in,
	output logic [15:0] sd_out,
	output logic [15:0] sd_oe_n,
	output logic io16_n,
	output logic disk_irq,
	// Drive and board pins
	input wire logic index_pulse_bit,
	input wire logic diskette_change_flag,
	input wire logic floppy_present,
	// Fixed-disk status from the controller side
	input wire logic controller_busy_flag,
	input wire logic drive_ready,
	input wire logic serial_error_any,
	input wire logic status_load,
	input wire logic [7:0] status_loaded,
	input wire logic disk_irq_pending,
	// Drive control signals from the controller side
	input wire logic write_gate_active_low,
	input wire logic head_load,
	input wire logic [3:0] head_select_new,
	input wire logic [1:0] drive_select_active_low,
	output logic disk_reset,
	// Sector buffer controller port
	input wire logic sector_start,
	input wire logic sector_to_host,
	input wire logic ctl_req,
	input wire logic ctl_we,
	input wire logic [7:0] ctl_addr,
	input wire logic [15:0] ctl_wdata,
	output logic ctl_gnt,
	output logic ctl_rvalid,
	output logic [15:0] ctl_rdata,
	// Floppy controller core
	input wire logic [7:0] fdc_status,
	input wire logic [7:0] fdc_result,
	output logic fdc_cmd_wr,
	output logic [7:0] fdc_cmd_byte,
	output logic fdc_res_rd,
	output logic motor_a_enable,
	output logic motor_b_enable,
	output logic floppy_irq_dma_enable,
	output logic drive_b_choice,
	output logic fdc_run,
	output logic [1:0] floppy_rate
);
	localparam int PW = $clog2(WORDS);
	localparam int SW = 32;

	// Refuse shapes the sector logic cannot serve
	initial
	begin
		if (WORDS != 256)
			$error("dchr_host_regs: sector must be 256 words");
		if (RST_MIN_CYC < 1 || RST_MIN_CYC > 65535)
			$error("dchr_host_regs: bad reset count");
	end

	// Two-stage synchronisers for every pin input
	logic [SW-1:0] pin_raw;
	logic [SW-1:0] pin_s1_r;
	logic [SW-1:0] pin_s2_r;
	assign pin_raw = {sa, aen, ior_n, iow_n, sd_in, index_pulse_bit,
		diskette_change_flag, floppy_present};
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			// Strobes and address enable start idle, so no false edge follows reset
			pin_s1_r <= 32'h0038_0000;
			pin_s2_r <= 32'h0038_0000;
		end
		else
		begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
		end
	end

	logic [9:0] sa_s;
	logic aen_s, ior_n_s, iow_n_s, idx_s, dchg_s, fpres_s;
	logic [15:0] sd_s;
	assign {sa_s, aen_s, ior_n_s, iow_n_s, sd_s, idx_s, dchg_s, fpres_s} = pin_s2_r;

	// Strobe edges; reset value of the stage before makes strobes look idle
	logic ior_d_r, iow_d_r;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ior_d_r <= 1'b1;
			iow_d_r <= 1'b1;
		end
		else
		begin
			ior_d_r <= ior_n_s;
			iow_d_r <= iow_n_s;
		end
	end
	logic rd_start, rd_end, wr_end;
	assign rd_start = ior_d_r && !ior_n_s;
	assign rd_end = !ior_d_r && ior_n_s;
	assign wr_end = !iow_d_r && iow_n_s;

	// Address decode, gated by address enable
	dchr_sel_t sel;
	always_comb
	begin
		sel = DCHR_SEL_NONE;
		if (!aen_s)
		begin
			case (sa_s)
				`DCHR_ADDR_DATA: sel = DCHR_SEL_DATA;
				`DCHR_ADDR_FOPS: sel = DCHR_SEL_FOPS;
				`DCHR_ADDR_FMSR: sel = DCHR_SEL_FMSR;
				`DCHR_ADDR_FSTK: sel = DCHR_SEL_FSTK;
				`DCHR_ADDR_AUX: sel = DCHR_SEL_AUX;
				`DCHR_ADDR_DIAG: sel = DCHR_SEL_DIAG;
				default: sel = DCHR_SEL_NONE;
			endcase
		end
	end

	// Auxiliary control: reset and interrupt disable
	logic aux_rst_r, ids_r;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aux_rst_r <= 1'b0;
			ids_r <= `DCHR_AUX_IDS_RST;
		end
		else if (wr_end && sel == DCHR_SEL_AUX)
		begin
			aux_rst_r <= sd_s[`DCHR_AUX_RST_BIT];
			ids_r <= sd_s[`DCHR_AUX_IDS_BIT];
		end
	end

	// Reset stretch: a too-short host pulse still gives a full reset
	logic [15:0] rst_cnt_r;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rst_cnt_r <= 16'h0000;
		else if (aux_rst_r)
			rst_cnt_r <= 16'(RST_MIN_CYC);
		else if (rst_cnt_r != 16'h0000)
			rst_cnt_r <= rst_cnt_r - 16'h0001;
	end
	assign disk_reset = aux_rst_r || (rst_cnt_r != 16'h0000);

	// Interrupt only masked; the pending request stays with its source
	assign disk_irq = disk_irq_pending && !ids_r;

	// Status bits loaded at sector transfer time
	logic [7:0] stat_ld_r;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			stat_ld_r <= 8'h00;
		else if (disk_reset)
			stat_ld_r <= 8'h00;
		else if (status_load)
			stat_ld_r <= status_loaded;
	end

	// Head selects only change when the control processor refreshes them
	logic [3:0] head_r;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			head_r <= 4'hf;
		else if (head_load)
			head_r <= head_select_new;
	end

	// Sector data path state
	logic [PW-1:0] host_ptr_r;
	logic drq_r, dir_to_host_r, fetch_r, wpend_r, mem_rd_host_r;
	logic [15:0] rd_pipe_r, wr_pipe_r, mem_rdata;
	logic host_need, mem_en, mem_we;
	logic [PW-1:0] mem_addr;
	logic [15:0] mem_wdata;
	logic data_done;
	assign data_done = drq_r && sel == DCHR_SEL_DATA
		&& ((rd_end && dir_to_host_r) || (wr_end && !dir_to_host_r));

	// Arbiter: host pipeline first, controller otherwise
	assign host_need = fetch_r || wpend_r;
	assign ctl_gnt = ctl_req && !host_need;
	assign mem_en = host_need || ctl_req;
	assign mem_we = host_need ? wpend_r : ctl_we;
	// Pointer has already moved past a pending host write word
	assign mem_addr = host_need ? (wpend_r ? host_ptr_r - 1'b1 : host_ptr_r)
		: ctl_addr[PW-1:0];
	assign mem_wdata = host_need ? wr_pipe_r : ctl_wdata;

	// Host word pointer and data request
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			host_ptr_r <= '0;
			drq_r <= 1'b0;
			dir_to_host_r <= 1'b0;
		end
		else if (disk_reset)
		begin
			host_ptr_r <= '0;
			drq_r <= 1'b0;
		end
		else if (sector_start)
		begin
			host_ptr_r <= '0;
			drq_r <= 1'b1;
			dir_to_host_r <= sector_to_host;
		end
		else if (data_done)
		begin
			host_ptr_r <= host_ptr_r + 1'b1;
			if (host_ptr_r == PW'(`DCHR_LAST_WORD))
				drq_r <= 1'b0;
		end
	end

	// Read pipeline: prefetch each word ahead of the host
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			fetch_r <= 1'b0;
		else if (disk_reset)
			fetch_r <= 1'b0;
		else if (sector_start)
			fetch_r <= sector_to_host;
		else if (data_done && dir_to_host_r && host_ptr_r != PW'(`DCHR_LAST_WORD))
			fetch_r <= 1'b1;
		else if (!wpend_r)
			fetch_r <= 1'b0;
	end

	// Write pipeline: host word waits here for its memory slot
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wpend_r <= 1'b0;
			wr_pipe_r <= 16'h0000;
		end
		else if (disk_reset)
			wpend_r <= 1'b0;
		else if (data_done && !dir_to_host_r)
		begin
			wpend_r <= 1'b1;
			wr_pipe_r <= sd_s;
		end
		else
			wpend_r <= 1'b0;
	end

	// Route registered memory data to host pipe or controller
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mem_rd_host_r <= 1'b0;
			ctl_rvalid <= 1'b0;
		end
		else
		begin
			mem_rd_host_r <= fetch_r && !wpend_r;
			ctl_rvalid <= ctl_gnt && !ctl_we;
		end
	end
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rd_pipe_r <= 16'h0000;
		else if (mem_rd_host_r)
			rd_pipe_r <= mem_rdata;
	end
	assign ctl_rdata = mem_rdata;

	dchr_sector_ram #(.WIDTH(16), .DEPTH(WORDS)) u_ram (
		.clock(clock),
		.en(mem_en),
		.we(mem_we),
		.addr(mem_addr),
		.wdata(mem_wdata),
		.rdata(mem_rdata)
	);

	// Floppy operations register; drive bits ignore command unit fields
	logic [7:0] fops_r;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			fops_r <= `DCHR_FOPS_RST_VAL;
		else if (wr_end && sel == DCHR_SEL_FOPS)
			fops_r <= sd_s[7:0];
	end
	assign motor_b_enable = fops_r[`DCHR_FOPS_MBE_BIT];
	assign motor_a_enable = fops_r[`DCHR_FOPS_MAE_BIT];
	assign floppy_irq_dma_enable = fops_r[`DCHR_FOPS_IDE_BIT];
	assign drive_b_choice = fops_r[`DCHR_FOPS_DSB_BIT];
	assign fdc_run = fops_r[`DCHR_FOPS_RST_BIT] && fops_r[`DCHR_FOPS_IDE_BIT];

	// Data rate; floppy section reset also restores the default
	dchr_rate_t rate_r;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rate_r <= DCHR_RATE_250K;
		else if (!fops_r[`DCHR_FOPS_RST_BIT])
			rate_r <= DCHR_RATE_250K;
		else if (wr_end && sel == DCHR_SEL_DIAG)
			rate_r <= dchr_rate_t'(sd_s[1:0]);
	end
	assign floppy_rate = rate_r;

	// Command bytes pushed and result bytes popped through one address
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fdc_cmd_wr <= 1'b0;
			fdc_res_rd <= 1'b0;
			fdc_cmd_byte <= 8'h00;
		end
		else
		begin
			fdc_cmd_wr <= wr_end && sel == DCHR_SEL_FSTK;
			fdc_res_rd <= rd_end && sel == DCHR_SEL_FSTK;
			if (wr_end && sel == DCHR_SEL_FSTK)
				fdc_cmd_byte <= sd_s[7:0]; // Option bits passed as sent
		end
	end

	// Read value of each register
	logic [7:0] alt_stat, diag;
	logic [15:0] rd_val;
	logic [15:0] rd_oe_n;
	always_comb
	begin
		alt_stat = stat_ld_r & 8'h35;
		alt_stat[7] = controller_busy_flag;
		alt_stat[6] = drive_ready;
		alt_stat[5] = stat_ld_r[5] || serial_error_any;
		alt_stat[3] = drq_r;
		alt_stat[1] = idx_s;
		diag = {dchg_s, write_gate_active_low, head_r, drive_select_active_low};
		rd_val = 16'h0000;
		rd_oe_n = 16'hff00;
		case (sel)
			DCHR_SEL_DATA:
			begin
				rd_val = rd_pipe_r;
				rd_oe_n = 16'h0000;
			end
			DCHR_SEL_FMSR: rd_val[7:0] = fdc_status & `DCHR_FMSR_ZERO_MASK;
			DCHR_SEL_FSTK: rd_val[7:0] = fdc_result;
			DCHR_SEL_AUX: rd_val[7:0] = alt_stat;
			DCHR_SEL_DIAG:
			begin
				rd_val[7:0] = diag;
				rd_oe_n[7] = !fpres_s;
			end
			DCHR_SEL_NONE: rd_oe_n = 16'hffff;
			default: rd_oe_n = 16'hffff;
		endcase
	end

	// Bus drivers: data latched at strobe start, released when it ends
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sd_out <= 16'h0000;
			sd_oe_n <= 16'hffff;
		end
		else if (rd_start)
		begin
			sd_out <= rd_val;
			sd_oe_n <= rd_oe_n;
		end
		else if (ior_n_s)
			sd_oe_n <= 16'hffff;
	end

	// 16-bit cycle indication for the data port only
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			io16_n <= 1'b1;
		else
			io16_n <= !(sel == DCHR_SEL_DATA);
	end
endmodule
`default_nettype wire

// ==== bench/dchr_host_regs_sva.sv ====
// Port-level assertions for the disk register bank
`timescale 1ns/1ps
`default_nettype none
module dchr_host_regs_sva #(
	parameter int RST_MIN_CYC = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Host bus
	input wire logic iow_n,
	input wire logic [15:0] sd_oe_n,
	input wire logic io16_n,
	input wire logic disk_irq,
	input wire logic disk_irq_pending,
	input wire logic disk_reset,
	// Buffer port
	input wire logic ctl_req,
	input wire logic ctl_we,
	input wire logic ctl_gnt,
	input wire logic ctl_rvalid,
	// Floppy side
	input wire logic fdc_cmd_wr,
	input wire logic fdc_res_rd,
	input wire logic motor_a_enable,
	input wire logic motor_b_enable,
	input wire logic floppy_irq_dma_enable,
	input wire logic drive_b_choice,
	input wire logic fdc_run,
	input wire logic [1:0] floppy_rate
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_irq_masked: assert property (disk_irq |-> disk_irq_pending)
		else $error("irq without pending source");
	a_irq_reset_off: assert property ($rose(rst_n) |-> !disk_irq)
		else $error("irq enabled after reset");
	a_rate_reset: assert property ($rose(rst_n) |-> floppy_rate == 2'h2)
		else $error("rate not default after reset");
	a_run_needs_ide: assert property (fdc_run |-> floppy_irq_dma_enable)
		else $error("floppy runs without enable");
	a_word_lanes: assert property (sd_oe_n[15:8] != 8'hff |-> sd_oe_n == 16'h0000 && !io16_n)
		else $error("partial word on data port");
	// Ops outputs only move after a write strobe
	a_ops_stable: assert property (iow_n [*6] |=> $stable({motor_a_enable, motor_b_enable,
		floppy_irq_dma_enable, drive_b_choice, fdc_run}))
		else $error("ops outputs moved without write");
	a_rvalid_cause: assert property (ctl_rvalid |-> $past(ctl_req && ctl_gnt && !ctl_we))
		else $error("read data without granted read");
	a_reset_stretch: assert property ($rose(disk_reset) |=> disk_reset [*4])
		else $error("disk reset too short");
	a_cmd_pulse: assert property (fdc_cmd_wr |=> !fdc_cmd_wr)
		else $error("command strobe longer than a cycle");
	a_res_pulse: assert property (fdc_res_rd |=> !fdc_res_rd)
		else $error("result strobe longer than a cycle");

	// Main scenarios reached
	c_irq: cover property (disk_irq);
	c_run: cover property (fdc_run);
	c_rvalid: cover property (ctl_rvalid);
	c_res: cover property (fdc_res_rd);
endmodule
bind dchr_host_regs dchr_host_regs_sva #(.RST_MIN_CYC(RST_MIN_CYC)) dchr_host_regs_sva_i (.*);
`default_nettype wire

// ==== bench/dchr_host_model.sv ====
// Host processor model issuing programmed I/O cycles
`timescale 1ns/1ps
`default_nettype none
module dchr_host_model (
	// Clock
	input wire logic clock,
	// Bus
	output logic [9:0] sa,
	output logic aen,
	output logic ior_n,
	output logic iow_n,
	output logic [15:0] sd_in,
	input wire logic [15:0] sd_out,
	input wire logic [15:0] sd_oe_n
);
	// Idle bus
	initial
	begin
		sa = 10'h000;
		aen = 1'b0;
		ior_n = 1'b1;
		iow_n = 1'b1;
		sd_in = 16'h0000;
	end

	// Write, whole word always; data flips once released so stale values never count
	task automatic wr(input logic [9:0] a, input logic [15:0] v);
		@(posedge clock) #1;
		sa = a;
		sd_in = v;
		iow_n = 1'b0;
		repeat (6) @(posedge clock);
		#1 iow_n = 1'b1;
		repeat (6) @(posedge clock);
		#1 sd_in = ~v;
	endtask

	// Read, sampled at the edge before the strobe ends
	task automatic rd(input logic [9:0] a, output logic [15:0] v, output logic [15:0] oe);
		@(posedge clock) #1;
		sa = a;
		ior_n = 1'b0;
		repeat (6) @(posedge clock);
		v = sd_out;
		oe = sd_oe_n;
		#1 ior_n = 1'b1;
		repeat (6) @(posedge clock);
		#1;
	endtask
endmodule
`default_nettype wire

// ==== bench/dchr_host_regs_tb.sv ====
// Self-checking bench for the disk register bank
`timescale 1ns/1ps
`default_nettype none
`include "dchr_defines.svh"
module dchr_host_regs_tb;
	logic clock = 1'b0;
	logic rst_n, aen, ior_n, iow_n, io16_n, disk_irq, index_pulse_bit, diskette_change_flag;
	logic floppy_present, controller_busy_flag, drive_ready, serial_error_any, status_load;
	logic disk_irq_pending, write_gate_active_low, head_load, disk_reset, sector_start;
	logic sector_to_host, ctl_req, ctl_we, ctl_gnt, ctl_rvalid, fdc_cmd_wr, fdc_res_rd;
	logic motor_a_enable, motor_b_enable, floppy_irq_dma_enable, drive_b_choice, fdc_run;
	logic [9:0] sa;
	logic [15:0] sd_in, sd_out, sd_oe_n, ctl_wdata, ctl_rdata, d, oe;
	logic [7:0] status_loaded, ctl_addr, fdc_status, fdc_result, fdc_cmd_byte;
	logic [3:0] head_select_new;
	logic [1:0] drive_select_active_low, floppy_rate;
	int miscompares = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;

	dchr_host_regs #(.RST_MIN_CYC(4)) dchr_host_regs_i (.*);
	dchr_host_model dchr_host_model_i (.*);

	// Clock
	always #10 clock = ~clock;

	// Hang guard, far above the expected run of about 7450 cycles
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			miscompares++;
			test_done;
		end
	end

	task automatic test_done;
		if (miscompares == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Read a port, compare lane enables and the driven bits
	task automatic rchk(input logic [9:0] a, input logic [15:0] eoe, input logic [15:0] e);
		dchr_host_model_i.rd(a, d, oe);
		chk(oe, eoe);
		chk(d & ~eoe, e);
	endtask

	// Controller buffer access, request held until granted
	task automatic cacc(input logic w, input logic [7:0] a, input logic [15:0] v);
		int i;
		@(posedge clock) #1;
		ctl_req = 1'b1;
		ctl_we = w;
		ctl_addr = a;
		ctl_wdata = v;
		while (ctl_gnt !== 1'b1) @(posedge clock) #1;
		@(posedge clock) #1;
		ctl_req = 1'b0;
		for (i = 0; i < 3 && !w && ctl_rvalid !== 1'b1; i++) @(posedge clock) #1;
		if (!w)
			chk(ctl_rdata, v);
	endtask

	task automatic sstart(input logic to_host);
		@(posedge clock) #1;
		sector_to_host = to_host;
		sector_start = 1'b1;
		@(posedge clock) #1;
		sector_start = 1'b0;
		repeat (4) @(posedge clock);
	endtask

	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		{index_pulse_bit, diskette_change_flag, controller_busy_flag, drive_ready} = '0;
		{serial_error_any, status_load, status_loaded, disk_irq_pending, head_load} = '0;
		{write_gate_active_low, head_select_new, drive_select_active_low} = '0;
		{sector_start, sector_to_host, ctl_req, ctl_we, ctl_addr, ctl_wdata} = '0;
		{fdc_status, fdc_result} = '0;
		floppy_present = 1'b1;
		repeat (4) @(posedge clock);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clock);
		#1 chk(16'(floppy_rate), 16'h0002);
		chk(16'(disk_irq), 16'h0000);
		// Live and loaded status bits, serial error shown as write fault
		controller_busy_flag = 1'b1;
		serial_error_any = 1'b1;
		index_pulse_bit = 1'b1;
		disk_irq_pending = 1'b1;
		status_loaded = 8'h15;
		status_load = 1'b1;
		@(posedge clock) #1;
		status_load = 1'b0;
		status_loaded = 8'h00;
		rchk(`DCHR_ADDR_AUX, 16'hff00, 16'h00b7);
		index_pulse_bit = 1'b0;
		rchk(`DCHR_ADDR_AUX, 16'hff00, 16'h00b5);
		// Interrupt mask keeps the pending request
		dchr_host_model_i.wr(`DCHR_ADDR_AUX, 16'h0000);
		chk(16'(disk_irq), 16'h0001);
		rchk(`DCHR_ADDR_AUX, 16'hff00, 16'h00b5);
		chk(16'(disk_irq), 16'h0001);
		dchr_host_model_i.wr(`DCHR_ADDR_AUX, 16'h0002);
		chk(16'(disk_irq), 16'h0000);
		dchr_host_model_i.wr(`DCHR_ADDR_AUX, 16'h0000);
		chk(16'(disk_irq), 16'h0001);
		// Soft reset held across a whole write cycle, longer than the scaled minimum
		dchr_host_model_i.wr(`DCHR_ADDR_AUX, 16'h0004);
		chk(16'(disk_reset), 16'h0001);
		dchr_host_model_i.wr(`DCHR_ADDR_AUX, 16'h0000);
		chk(16'(disk_reset), 16'h0001); // Still stretched
		repeat (4) @(posedge clock);
		#1 chk(16'(disk_reset), 16'h0000);
		// Diagnostic input with refreshed head selects, then option absent
		head_select_new = 4'ha;
		head_load = 1'b1;
		drive_select_active_low = 2'b01;
		diskette_change_flag = 1'b1;
		@(posedge clock) #1;
		head_load = 1'b0;
		rchk(`DCHR_ADDR_DIAG, 16'hff00, 16'h00a9);
		floppy_present = 1'b0;
		rchk(`DCHR_ADDR_DIAG, 16'hff80, 16'h0029);
		floppy_present = 1'b1;
		// Floppy status, operations and rate
		fdc_status = 8'hff;
		rchk(`DCHR_ADDR_FMSR, 16'hff00, 16'h00f3);
		dchr_host_model_i.wr(`DCHR_ADDR_FOPS, 16'h003d);
		chk(16'({motor_b_enable, motor_a_enable, floppy_irq_dma_enable, drive_b_choice,
			fdc_run}), 16'h001f);
		dchr_host_model_i.wr(`DCHR_ADDR_DIAG, 16'h0000);
		chk(16'(floppy_rate), 16'h0000);
		dchr_host_model_i.wr(`DCHR_ADDR_FOPS, 16'h0008);
		chk(16'({fdc_run, floppy_rate}), 16'h0002);
		dchr_host_model_i.wr(`DCHR_ADDR_FOPS, 16'h000c);
		dchr_host_model_i.wr(`DCHR_ADDR_FSTK, 16'h0007);
		chk(16'(fdc_cmd_byte), 16'h0007);
		fdc_result = 8'h5a;
		rchk(`DCHR_ADDR_FSTK, 16'hff00, 16'h005a);
		// Sector to host: buffer filled by controller, drained by host words
		for (n = 0; n < 256; n++)
			cacc(1'b1, n[7:0], {~n[7:0], n[7:0]});
		sstart(1'b1);
		rchk(`DCHR_ADDR_AUX, 16'hff00, 16'h00a8);
		for (n = 0; n < 256; n++)
			rchk(`DCHR_ADDR_DATA, 16'h0000, {~n[7:0], n[7:0]});
		rchk(`DCHR_ADDR_AUX, 16'hff00, 16'h00a0);
		// Sector from host, then controller reads both ends
		sstart(1'b0);
		for (n = 0; n < 256; n++)
			dchr_host_model_i.wr(`DCHR_ADDR_DATA, {n[7:0], ~n[7:0]});
		cacc(1'b0, 8'h00, 16'h00ff);
		cacc(1'b0, 8'hff, 16'hff00);
		test_done;
	end
endmodule
`default_nettype wire
